/* common/erm_defs.svh */
// register map constants for the error record group msi register bank
// assumes inclusion by the package and the design module
`ifndef ERM_DEFS_SVH
`define ERM_DEFS_SVH
`define ERM_OFF_ADDR_LO 12'hE90
`define ERM_OFF_ADDR_HI 12'hE94
`define ERM_OFF_PAYLOAD 12'hE98
`define ERM_OFF_ATTR 12'hE9C
`define ERM_OFF_ARCH_ID 12'hFBC
`define ERM_OFF_GRP_CFG 12'hFC8
`define ERM_ARCH_PRESENT 1'h1
`define ERM_ARCH_REV 4'h1
`define ERM_ADDR_LO_BIT 2
`define ERM_ADDR_HI_BIT 55
`define ERM_ATTR_SPACE_BIT 6
`define ERM_ATTR_EN_BIT 7
`define ERM_MAX_REC_FI 24
`define ERM_MAX_REC_NOFI 56
`endif

/* common/erm_pkg.sv */
// types for the error record group msi register bank
// assumes erm_defs.svh is on the include path
`include "erm_defs.svh"
package erm_pkg;
  typedef enum logic [1:0] {
    ERM_SEC_SECURE = 2'h0,
    ERM_SEC_NONSECURE = 2'h1,
    ERM_SEC_REALM = 2'h2,
    ERM_SEC_ROOT = 2'h3
  } erm_space_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    erm_space_e space;
  } erm_req_s;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [31:0] data;
    logic non_secure;
  } erm_msi_s;

  typedef enum logic [1:0] {
    ERM_ST_IDLE = 2'h0,
    ERM_ST_SEND = 2'h1
  } erm_state_e;
endpackage : erm_pkg

/* rtl/erm_regs.sv */
// register bank: discovery registers and error recovery msi configuration
// assumes a single-cycle word register port and an msi sink with ready
`timescale 1ns/1ps
`default_nettype none
`include "erm_defs.svh"

// How it works
// R1: architecture id register readable at 0xFBC, read-only.
// R2: bits 31:21 hold architect continuation code and id code.
// R3: bit 20 always reads one.
// R4: bits 19:16 report architecture revision.
// R5: bits 15:12 report fixed architecture version.
// R6: bits 11:0 report fixed architecture part number.
// R7: group config register at 0xFC8, upper half reads zero.
// R8: low half reports highest record index plus one, constant.
// R9: record count capped at 24 with fault injection, else 56.
// R10: 64-bit read/write msi address register at 0xE90.
// R11: address register is the same storage as config array index two.
// R12: address field bits 55:2, other bits read zero, used shifted.
// R13: bits above implemented address width read zero; reset leaves unknown.
// R14: 32-bit payload register at 0xE98, config array index three low.
// R15: payload is whole msi write data; not reset.
// R16: non-secure or realm writes ignored while space select is secure.
// R17: alternative layout defines its own read and write behaviour.
// R18: absent registers read zero and ignore writes.
// R19: attribute bit 6 picks secure or non-secure target space.
// R20: raised interrupt with enable sends one payload write to address.
module erm_regs #(
  parameter int PA_WIDTH = 48,
  parameter int NUM_RECORDS = 16,
  parameter bit FAULT_INJ = 1'b0,
  parameter bit IRQ_CFG_PRESENT = 1'b1,
  parameter bit RECOVERY_IRQ_PRESENT = 1'b1,
  parameter bit ALT_LAYOUT = 1'b0,
  // arbitrary neutral identity values
  parameter logic [3:0] ARCHITECT_CONT = 4'h0,
  parameter logic [6:0] ARCHITECT_CODE = 7'h00,
  parameter logic [3:0] ARCH_VERSION = 4'h0,
  parameter logic [11:0] ARCH_PART = 12'h000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire erm_pkg::erm_req_s req_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  // error recovery event
  input wire logic recovery_irq_in,
  // msi write toward the interrupt controller
  output erm_pkg::erm_msi_s msi_out,
  input wire logic msi_ready_in
);
  localparam int MAX_REC = FAULT_INJ ? `ERM_MAX_REC_FI : `ERM_MAX_REC_NOFI;
  localparam bit PRESENT = IRQ_CFG_PRESENT && (RECOVERY_IRQ_PRESENT || ALT_LAYOUT); // R18

  initial
  begin
    if (NUM_RECORDS < 1 || NUM_RECORDS > MAX_REC) // R9
      $error("record count out of range");
    if (PA_WIDTH < 3 || PA_WIDTH > `ERM_ADDR_HI_BIT + 1)
      $error("address width out of range");
  end

  // implemented address bits only; upper ones read zero
  localparam logic [63:0] ADDR_MASK =
    ((64'h1 << PA_WIDTH) - 64'h1) & ~64'h3; // R12 R13

  logic [63:0] addr_r; // irq_config_index_two storage, R11
  logic [31:0] payload_r; // irq_config_index_three low half, R14
  logic space_sel_r;
  logic msi_en_r;
  logic pending_r;
  erm_pkg::erm_msi_s msi_r;
  erm_pkg::erm_state_e state_r;

  logic wr;
  logic sec_lock;
  logic wr_ok;
  assign wr = req_in.valid && req_in.write;
  // a secure-targeted msi may only be retargeted by secure or root
  assign sec_lock = !ALT_LAYOUT && !space_sel_r &&
    (req_in.space == erm_pkg::ERM_SEC_NONSECURE || req_in.space == erm_pkg::ERM_SEC_REALM); // R16
  assign wr_ok = wr && PRESENT && !sec_lock; // R18

  // address: no reset, matches the unknown reset value of the field
  always_ff @(posedge clk_in)
  begin
    if (wr_ok && req_in.addr == `ERM_OFF_ADDR_LO) // R10
      addr_r[31:0] <= req_in.wdata & ADDR_MASK[31:0]; // R12
    if (wr_ok && req_in.addr == `ERM_OFF_ADDR_HI)
      addr_r[63:32] <= req_in.wdata & ADDR_MASK[63:32]; // R13
  end

  // payload also left unreset
  always_ff @(posedge clk_in)
  begin
    if (wr_ok && req_in.addr == `ERM_OFF_PAYLOAD)
      payload_r <= req_in.wdata; // R14 R15
  end

  // attribute bits; alternative layout reuses the same simple storage, R17
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      msi_en_r <= 1'b0;
      space_sel_r <= 1'b0;
    end
    else if (wr_ok && req_in.addr == `ERM_OFF_ATTR)
    begin
      msi_en_r <= req_in.wdata[`ERM_ATTR_EN_BIT];
      if (req_in.space != erm_pkg::ERM_SEC_NONSECURE && req_in.space != erm_pkg::ERM_SEC_REALM)
        space_sel_r <= req_in.wdata[`ERM_ATTR_SPACE_BIT]; // R19
    end
  end

  // read path, one cycle latency
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= 32'h0000_0000;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= req_in.valid && !req_in.write;
      rdata_out <= 32'h0000_0000;
      if (req_in.valid && !req_in.write)
        case (req_in.addr)
          `ERM_OFF_ARCH_ID: rdata_out <= {ARCHITECT_CONT, ARCHITECT_CODE, // R1 R2
            `ERM_ARCH_PRESENT, `ERM_ARCH_REV, ARCH_VERSION, ARCH_PART}; // R3 R4 R5 R6
          `ERM_OFF_GRP_CFG: rdata_out <= {16'h0000, 16'(NUM_RECORDS)}; // R7 R8
          `ERM_OFF_ADDR_LO: rdata_out <= PRESENT ? addr_r[31:0] : 32'h0000_0000; // R11 R18
          `ERM_OFF_ADDR_HI: rdata_out <= PRESENT ? addr_r[63:32] : 32'h0000_0000;
          `ERM_OFF_PAYLOAD: rdata_out <= PRESENT ? payload_r : 32'h0000_0000;
          `ERM_OFF_ATTR: rdata_out <= PRESENT ?
            {24'h000000, msi_en_r, space_sel_r, 6'h00} : 32'h0000_0000;
          default: rdata_out <= 32'h0000_0000;
        endcase
    end
  end

  // recovery event latch; a new event merges with a queued one unless the sender takes that one in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      pending_r <= 1'b0;
    else if (recovery_irq_in && msi_en_r && PRESENT)
      pending_r <= 1'b1;
    else if (state_r == erm_pkg::ERM_ST_IDLE && pending_r)
      pending_r <= 1'b0;
  end

  // msi sender: one write per pending event
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= erm_pkg::ERM_ST_IDLE;
      msi_r <= '0;
    end
    else
      case (state_r)
        erm_pkg::ERM_ST_IDLE:
          if (pending_r)
          begin
            msi_r.valid <= 1'b1; // R20
            msi_r.addr <= addr_r & ADDR_MASK; // R12
            msi_r.data <= payload_r; // R15
            msi_r.non_secure <= space_sel_r; // R19
            state_r <= erm_pkg::ERM_ST_SEND;
          end
        erm_pkg::ERM_ST_SEND:
          if (msi_ready_in)
          begin
            msi_r.valid <= 1'b0;
            state_r <= erm_pkg::ERM_ST_IDLE;
          end
        default: state_r <= erm_pkg::ERM_ST_IDLE;
      endcase
  end

  assign msi_out = msi_r;
endmodule : erm_regs
`default_nettype wire

/* verification/erm_msi_sink.sv */
// partner: msi sink in the interrupt controller, can stall
// assumes the bank's msi output on the same clock
`timescale 1ns/1ps
`default_nettype none
module erm_msi_sink (
  input wire logic clk_in,
  input wire erm_pkg::erm_msi_s msi_in,
  input wire logic stall_in,
  output logic ready_out,
  output logic [7:0] count_out = 8'h0,
  output erm_pkg::erm_msi_s last_out
);
  assign ready_out = !stall_in;
  always @(posedge clk_in)
    if (msi_in.valid && ready_out)
    begin
      count_out <= count_out + 8'h1;
      last_out <= msi_in;
    end
endmodule : erm_msi_sink
`default_nettype wire

/* verification/erm_regs_checker.sv */
// checker: register port and msi output relations of the bank
// assumes default identity parameters
`timescale 1ns/1ps
`default_nettype none
module erm_regs_checker #(parameter int NUM_RECORDS = 16) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire erm_pkg::erm_req_s req_in,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  input wire erm_pkg::erm_msi_s msi_out,
  input wire logic msi_ready_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic rd = req_in.valid && !req_in.write;
  read_answer_a: assert property (rd |=> rvalid_out) else $error("read unanswered");
  idle_quiet_a: assert property (!rd |=> !rvalid_out && rdata_out == 32'h0)
    else $error("read data outside a read");
  arch_word_a: assert property (rd && req_in.addr == 12'hFBC |=> rdata_out == 32'h0011_0000)
    else $error("architecture word wrong");
  rec_count_a: assert property (rd && req_in.addr == 12'hFC8 |=> rdata_out == NUM_RECORDS)
    else $error("record count wrong");
  addr_low_a: assert property (rd && req_in.addr == 12'hE90 |=> rdata_out[1:0] == 2'h0)
    else $error("address low bits set");
  addr_high_a: assert property (rd && req_in.addr == 12'hE94 |=> rdata_out[31:16] == 16'h0)
    else $error("address above width set");
  msi_hold_a: assert property (msi_out.valid && !msi_ready_in |=> $stable(msi_out))
    else $error("msi changed while stalled");
  msi_drop_a: assert property (msi_out.valid && msi_ready_in |=> !msi_out.valid)
    else $error("msi repeated");
  msi_align_a: assert property (msi_out.valid |-> msi_out.addr[1:0] == 2'h0)
    else $error("msi address unaligned");
endmodule : erm_regs_checker
bind erm_regs erm_regs_checker #(.NUM_RECORDS(NUM_RECORDS)) u_erm_regs_checker (.clk_in,
  .sys_rst_in, .req_in, .rdata_out, .rvalid_out, .msi_out, .msi_ready_in);
`default_nettype wire

/* verification/erm_regs_test.sv */
// testbench: discovery reads, address setup, locked writes, one stalled msi, one disabled event
// assumes erm_regs with default parameters and the erm_msi_sink partner
`timescale 1ns/1ps
`default_nettype none
module erm_regs_test;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic recovery_irq_in = 1'b0;
  logic stall = 1'b0;
  logic [31:0] rdata_out;
  logic rvalid_out;
  logic msi_ready_in;
  logic [7:0] msi_cnt;
  erm_pkg::erm_req_s req_in = '0;
  erm_pkg::erm_msi_s msi_out;
  erm_pkg::erm_msi_s msi_seen;
  int fail_count = 0;
  int cmp_count = 0;
  always #50 clk_in = ~clk_in;
  erm_regs u_erm_regs (.clk_in, .sys_rst_in, .req_in, .rdata_out, .rvalid_out,
    .recovery_irq_in, .msi_out, .msi_ready_in);
  erm_msi_sink u_erm_msi_sink (.clk_in, .msi_in(msi_out), .stall_in(stall),
    .ready_out(msi_ready_in), .count_out(msi_cnt), .last_out(msi_seen));
  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [97:0] exp, input logic [97:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] sp);
    @(negedge clk_in);
    req_in <= '{1'b1, wr, a, d, erm_pkg::erm_space_e'(sp)};
    @(negedge clk_in);
    req_in.valid <= 1'b0;
  endtask : acc
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 2'h0);
    chk("read", {1'b1, exp}, {rvalid_out, rdata_out});
  endtask : rd
  task automatic sc_discovery;
    rd(12'hFBC, 32'h0011_0000);
    rd(12'hFC8, 32'h0000_0010);
    rd(12'h000, 32'h0000_0000);
  endtask : sc_discovery
  task automatic sc_config;
    acc(1'b1, 12'hE90, 32'hFFFF_FFFF, 2'h0);
    acc(1'b1, 12'hE94, 32'hFFFF_FFFF, 2'h3);
    acc(1'b1, 12'hE98, 32'hA5C3_0F1E, 2'h0);
    rd(12'hE90, 32'hFFFF_FFFC);
    rd(12'hE94, 32'h0000_FFFF);
    acc(1'b1, 12'hE98, 32'h0000_0000, 2'h1);
    acc(1'b1, 12'hE90, 32'h0000_0000, 2'h2);
    rd(12'hE98, 32'hA5C3_0F1E);
    rd(12'hE90, 32'hFFFF_FFFC);
    acc(1'b1, 12'hE90, 32'h1234_567B, 2'h0);
    acc(1'b1, 12'hE9C, 32'h0000_00C0, 2'h0);
    acc(1'b1, 12'hE98, 32'h0BAD_F00D, 2'h1);
  endtask : sc_config
  // one event pulse gives exactly one write, held while the sink stalls
  task automatic sc_msi;
    @(negedge clk_in);
    recovery_irq_in <= 1'b1;
    stall <= 1'b1;
    @(negedge clk_in);
    recovery_irq_in <= 1'b0;
    for (int i = 0; i < 20 && msi_out.valid !== 1'b1; i++) @(negedge clk_in);
    chk("msi_valid", 98'h1, 98'(msi_out.valid));
    if (msi_out.valid !== 1'b1) complete_run();
    repeat (3) @(negedge clk_in);
    stall <= 1'b0;
    repeat (6) @(negedge clk_in);
    chk("msi", {1'b1, 64'h0000_FFFF_1234_5678, 32'h0BAD_F00D, 1'b1}, msi_seen);
    chk("msi_count", 98'h1, 98'(msi_cnt));
    acc(1'b1, 12'hE9C, 32'h0000_0040, 2'h0);
    rd(12'hE9C, 32'h0000_0040);
    @(negedge clk_in);
    recovery_irq_in <= 1'b1;
    @(negedge clk_in);
    recovery_irq_in <= 1'b0;
    repeat (6) @(negedge clk_in);
    chk("msi_count_disabled", 98'h1, 98'(msi_cnt));
  endtask : sc_msi
  initial
  begin
    repeat (10) @(negedge clk_in);
    sys_rst_in <= 1'b0;
    sc_discovery();
    sc_config();
    sc_msi();
    complete_run();
  end
endmodule : erm_regs_test
`default_nettype wire
